// ==== shared/sac_defines.vh ====
// Purpose: Shared constants for the converter control block.
// Assumes: 50 MHz system clock on mclk.
// Notes: Offsets are byte addresses on the system bus.
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// Register base addresses (little endian, or any word access).
`define SAC_CTRL_ADDR 32'h01D40000
`define SAC_DIV_ADDR 32'h01D40004
`define SAC_RES_ADDR 32'h01D40008

// Big endian lane offsets for narrow accesses.
`define SAC_BE_HW_OFS 32'h00000002
`define SAC_BE_B_OFS 32'h00000003
`define SAC_ZERO_OFS 32'h00000000

// Access size codes on bus_size.
`define SAC_SZ_BYTE 2'h0
`define SAC_SZ_HALF 2'h1
`define SAC_SZ_WORD 2'h2

// Control register fields.
`define SAC_CTRL_START 0
`define SAC_CTRL_RDSTART 1
`define SAC_CTRL_CHAN_LO 2
`define SAC_CTRL_CHAN_HI 4
`define SAC_CTRL_SLEEP 5
`define SAC_CTRL_FLAG 6
`define SAC_CTRL_RESET 7'h20
`define SAC_DIV_RESET 8'h00
`define SAC_RES_RESET 10'h000

// Conversion sequence, counted in conversion clocks after launch.
`define SAC_CCLK_TOTAL 5'h10
`define SAC_CCLK_FLAG 5'h0F
`define SAC_CCLK_GLITCH_END 5'h01
`define SAC_CCLK_LAST_BIT 5'h0A
`define SAC_RES_W 10
`define SAC_SAR_MSB 10'h200

// Settling times that software must respect, with derived cycle counts.
`define SAC_CLK_PERIOD_NS 20
`define SAC_REF_SETTLE_NS 10000000
`define SAC_REF_SETTLE_CYC (`SAC_REF_SETTLE_NS / `SAC_CLK_PERIOD_NS)
`define SAC_CHAN_SETUP_NS 15000
`define SAC_CHAN_SETUP_CYC \
  ((`SAC_CHAN_SETUP_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

`endif

// ==== rtl/sac_sar.v ====
// Purpose: Successive approximation register for a 10-bit result.
// Assumes: Comparator input already synchronised to mclk.
// Notes: The trial word comes straight from flip-flops.
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_sar (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // Sequencing.
  input wire init,
  input wire step,
  input wire cmp_hi,
  // Trial word toward the converter DAC.
  output reg [9:0] trial
);

  reg [9:0] probe;

  // Start at the MSB and walk one bit down per step.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trial <= `SAC_RES_RESET;
      probe <= `SAC_RES_RESET;
    end else if (init) begin
      trial <= `SAC_SAR_MSB;
      probe <= `SAC_SAR_MSB;
    end else if (step) begin
      // Keep the bit under trial only when the input stood above it.
      trial <= (cmp_hi ? trial : (trial & ~probe)) | (probe >> 1); // R18
      probe <= probe >> 1;
    end
  end

endmodule

// ==== rtl/sac_ctrl.v ====
// Purpose: Control logic of an 8-channel 10-bit successive approximation converter.
// Assumes: Single system clock mclk at 50 MHz; comparator output is asynchronous.
// Notes: Register file is reached over the system bus at its documented addresses.
//
// Overview of operation
// R01 - One conversion takes 16 conversion clocks, each 2*(P+1) system clocks.
// R02 - Sleep bit 5 stops the conversion clock and halts conversion.
// R03 - In sleep the result register keeps its last completed value.
// R04 - Control register resets to 0x20, sleep only.
// R05 - Software waits 10 ms after leaving sleep before converting.
// R06 - Channel field bits 4..2 selects analog input n.
// R07 - Software waits 15 us after a channel change before starting.
// R08 - Writing 1 to bit 0 starts; hardware clears it after start.
// R09 - Write start is ignored while start-by-read is enabled.
// R10 - With bit 1 set, a result read launches a new conversion.
// R11 - Flag bit 6 reads 0 while converting, 1 when ended.
// R12 - Flag glitches high after start and rises one clock early.
// R13 - Polling software waits start clear, flag set, then P loops.
// R14 - Start bit clears within one conversion clock of the start.
// R15 - Result register holds the 10-bit value in bits 9..0, read only.
// R16 - Software reads the result only after completion.
// R17 - Result takes halfword or word only; others also take bytes.
// R18 - Approximation resolves from MSB down, keeping bits when input is higher.
// R19 - End flag clears at launch and stays set from completion to next launch.
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_ctrl (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // System bus slave.
  input wire bus_sel,
  input wire bus_wr,
  input wire [31:0] bus_addr,
  input wire [1:0] bus_size,
  input wire bus_big_endian,
  input wire [31:0] bus_wdata,
  output reg [31:0] bus_rdata,
  output reg bus_ack,
  output reg bus_err,
  // Analog core.
  input wire an_cmp,
  output reg [2:0] analog_input_n,
  output wire [9:0] an_trial,
  output reg an_sleep,
  output reg an_busy
);

  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  // Control state.
  reg ctl_start;
  reg ctl_rdstart;
  reg [2:0] ctl_chan;
  reg ctl_sleep;
  reg [7:0] conversion_clock_divider;
  reg [9:0] conversion_result;
  reg end_flag;
  reg early_glitch;
  reg [1:0] state;
  reg [8:0] div_cnt;
  reg [4:0] cclk_cnt;
  reg cmp_meta;
  reg cmp_sync;

  // Bus decode.
  wire acc;
  wire hit_ctrl;
  wire hit_div;
  wire hit_res;
  wire res_size_ok;
  wire wr_ctrl;
  wire wr_div;
  wire rd_res;
  wire bad;

  // Sequencer strobes.
  wire [8:0] div_last;
  wire cclk_tick;
  wire launch;
  wire [4:0] next_cclk;
  wire sar_init;
  wire sar_step;
  wire [6:0] ctrl_view;

  // Register address for the access size and byte order in force.
  function addr_hit;
    input [31:0] addr;
    input [31:0] base;
    input [1:0] size;
    input big;
    reg [31:0] ofs;
    begin
      ofs = `SAC_ZERO_OFS;
      if (big && size == `SAC_SZ_HALF) begin
        ofs = `SAC_BE_HW_OFS;
      end else if (big && size == `SAC_SZ_BYTE) begin
        ofs = `SAC_BE_B_OFS;
      end
      addr_hit = (addr == base + ofs);
    end
  endfunction

  // The result word rejects byte accesses and all writes.
  assign acc = bus_sel;
  assign hit_ctrl = addr_hit(bus_addr, `SAC_CTRL_ADDR, bus_size, bus_big_endian); // R17
  assign hit_div = addr_hit(bus_addr, `SAC_DIV_ADDR, bus_size, bus_big_endian); // R17
  assign res_size_ok = (bus_size == `SAC_SZ_HALF) || (bus_size == `SAC_SZ_WORD); // R17
  assign hit_res = addr_hit(bus_addr, `SAC_RES_ADDR, bus_size, bus_big_endian)
    && res_size_ok && !bus_wr; // R17
  assign wr_ctrl = acc && bus_wr && hit_ctrl;
  assign wr_div = acc && bus_wr && hit_div;
  assign rd_res = acc && !bus_wr && hit_res;
  assign bad = acc && !(hit_ctrl || hit_div || hit_res);

  // Control register as software sees it; flag carries both known defects.
  assign ctrl_view = {end_flag | early_glitch, ctl_sleep, ctl_chan,
    ctl_rdstart, ctl_start}; // R11 R12

  // Input synchroniser for the asynchronous comparator output.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= an_cmp;
      cmp_sync <= cmp_meta;
    end
  end

  // Bus answers come one cycle after the access; narrow data sit low.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 32'h00000000;
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
    end else begin
      bus_ack <= acc && !bad;
      bus_err <= bad;
      if (acc && !bus_wr && hit_ctrl) begin
        bus_rdata <= {25'h0000000, ctrl_view};
      end else if (acc && !bus_wr && hit_div) begin
        bus_rdata <= {24'h000000, conversion_clock_divider};
      end else if (rd_res) begin
        bus_rdata <= {22'h000000, conversion_result}; // R15
      end else begin
        bus_rdata <= 32'h00000000;
      end
    end
  end

  // Conversion clock prescaler: one tick every 2*(P+1) system clocks.
  // Held at zero in sleep so the conversion clock really stops.
  assign div_last = {conversion_clock_divider, 1'b1}; // R01
  assign cclk_tick = !ctl_sleep && (div_cnt == div_last); // R01 R02

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 9'h000;
    end else if (ctl_sleep || cclk_tick) begin
      div_cnt <= 9'h000; // R02
    end else begin
      div_cnt <= div_cnt + 9'h001; // R01
    end
  end

  // A pending start is taken on the next conversion clock while idle.
  assign launch = cclk_tick && (state == ST_IDLE) && ctl_start;
  assign next_cclk = cclk_cnt + 5'h01;
  assign sar_init = launch;
  assign sar_step = cclk_tick && (state == ST_CONV) &&
    (next_cclk <= `SAC_CCLK_LAST_BIT); // R18

  // Control and divider registers. A write of 1 wins over the self clear.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_start <= 1'b0; // R04
      ctl_rdstart <= 1'b0;
      ctl_chan <= 3'h0;
      ctl_sleep <= 1'b1; // R04
      conversion_clock_divider <= `SAC_DIV_RESET;
    end else begin
      if (wr_ctrl) begin
        ctl_rdstart <= bus_wdata[`SAC_CTRL_RDSTART];
        ctl_chan <= bus_wdata[`SAC_CTRL_CHAN_HI:`SAC_CTRL_CHAN_LO]; // R06
        ctl_sleep <= bus_wdata[`SAC_CTRL_SLEEP]; // R02
      end
      if (wr_ctrl && bus_wdata[`SAC_CTRL_START] && !ctl_rdstart &&
          !bus_wdata[`SAC_CTRL_RDSTART]) begin
        ctl_start <= 1'b1; // R08 R09
      end else if (rd_res && ctl_rdstart) begin
        ctl_start <= 1'b1; // R10
      end else if (launch || (wr_ctrl && bus_wdata[`SAC_CTRL_RDSTART])) begin
        ctl_start <= 1'b0; // R14 R09
      end
      if (wr_div) begin
        conversion_clock_divider <= bus_wdata[7:0]; // R01
      end
    end
  end

  // Conversion sequencer. Sleep aborts a running conversion without
  // touching the result, so the previous value stays readable.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cclk_cnt <= 5'h00;
      end_flag <= 1'b0;
      early_glitch <= 1'b0;
      conversion_result <= `SAC_RES_RESET;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            state <= ST_CONV;
            cclk_cnt <= 5'h00;
            end_flag <= 1'b0; // R19 R11
            early_glitch <= 1'b1; // R12
          end
        end
        ST_CONV: begin
          if (ctl_sleep) begin
            state <= ST_IDLE; // R02 R03
            cclk_cnt <= 5'h00;
            early_glitch <= 1'b0;
          end else if (cclk_tick) begin
            cclk_cnt <= next_cclk;
            if (next_cclk == `SAC_CCLK_GLITCH_END) begin
              early_glitch <= 1'b0; // R12
            end
            if (next_cclk == `SAC_CCLK_FLAG) begin
              end_flag <= 1'b1; // R12 R19
            end
            if (next_cclk == `SAC_CCLK_TOTAL) begin
              conversion_result <= an_trial; // R15 R03
              state <= ST_IDLE; // R01
              cclk_cnt <= 5'h00;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          cclk_cnt <= 5'h00;
          early_glitch <= 1'b0;
        end
      endcase
    end
  end

  // Analog side outputs come from flip-flops.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      analog_input_n <= 3'h0;
      an_sleep <= 1'b1;
      an_busy <= 1'b0;
    end else begin
      analog_input_n <= ctl_chan; // R06
      an_sleep <= ctl_sleep; // R02
      an_busy <= (state == ST_CONV) && !ctl_sleep;
    end
  end

  // Bit trials use the comparator as seen through the synchroniser.
  sac_sar u_sar (
    .mclk(mclk),
    .rst_n(rst_n),
    .init(sar_init),
    .step(sar_step),
    .cmp_hi(cmp_sync),
    .trial(an_trial)
  );

endmodule

// ==== verification/sac_ctrl_asserts.sv ====
// Purpose: Port checker for the converter control block.
// Assumes: The divider is written with word accesses only.
// Notes: Bound into every sac_ctrl instance.
`timescale 1ns/1ps
`include "sac_defines.vh"
module sac_ctrl_chk (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // Bus side.
  input wire bus_sel,
  input wire bus_wr,
  input wire [31:0] bus_addr,
  input wire [1:0] bus_size,
  input wire [31:0] bus_wdata,
  input wire [31:0] bus_rdata,
  input wire bus_ack,
  input wire bus_err,
  // Analog side.
  input wire [2:0] analog_input_n,
  input wire [9:0] an_trial,
  input wire an_sleep,
  input wire an_busy
);
  logic [7:0] div;
  logic [2:0] chan;
  logic [13:0] bcnt;
  wire wr_w = bus_sel && bus_wr && bus_size == `SAC_SZ_WORD;
  wire ctl_wr = wr_w && bus_addr == `SAC_CTRL_ADDR;
  wire [8:0] dp1 = {1'b0, div} + 9'h001;
  wire [13:0] full = {dp1, 5'h00};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Shadow the divider and channel, and count the cycles of each busy spell.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 8'h00;
      chan <= 3'h0;
      bcnt <= 14'h0000;
    end else begin
      bcnt <= an_busy ? bcnt + 14'h0001 : 14'h0000;
      if (ctl_wr) begin
        chan <= bus_wdata[4:2];
      end
      if (wr_w && bus_addr == `SAC_DIV_ADDR) begin
        div <= bus_wdata[7:0];
      end
    end
  end
  // A sleep abort ends a spell early, so those spells are left out.
  conv_len_a: assert property ($fell(an_busy) && !an_sleep && !$past(ctl_wr) |->
    bcnt <= full && bcnt + 14'h0002 >= full) else $error("conversion length wrong");
  sleep_halt_a: assert property (an_sleep [*2] |-> !an_busy)
    else $error("busy while asleep");
  chan_route_a: assert property (ctl_wr |-> ##2 analog_input_n == chan)
    else $error("channel not routed");
  msb_first_a: assert property ($rose(an_busy) |-> an_trial == `SAC_SAR_MSB)
    else $error("first trial not msb");
  res_width_a: assert property (bus_ack && $past(bus_addr == `SAC_RES_ADDR) |->
    bus_rdata[31:10] == 22'h0) else $error("result upper bits set");
  res_write_a: assert property (bus_sel && bus_wr && bus_addr == `SAC_RES_ADDR |=>
    bus_err && !bus_ack) else $error("result write accepted");
  res_byte_a: assert property (bus_sel && bus_size == `SAC_SZ_BYTE &&
    bus_addr == `SAC_RES_ADDR |=> bus_err) else $error("result byte accepted");
  ctl_ack_a: assert property (ctl_wr |=> bus_ack && !bus_err)
    else $error("control write refused");
  answer_cause_a: assert property (bus_ack || bus_err |-> $past(bus_sel))
    else $error("answer without access");
  cover property ($rose(an_busy));
  cover property ($fell(an_busy) && !an_sleep);
  cover property (bus_err);
endmodule
bind sac_ctrl sac_ctrl_chk i_chk (.mclk(mclk), .rst_n(rst_n), .bus_sel(bus_sel),
  .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
  .analog_input_n(analog_input_n), .an_trial(an_trial), .an_sleep(an_sleep),
  .an_busy(an_busy));

// ==== verification/sac_core_model.sv ====
// Purpose: Behavioural analog core with channel mux and comparator.
// Assumes: Channel n level sits in bits 10n+9 to 10n of levels.
// Notes: Asleep, the comparator answers nonsense like an unpowered core.
`timescale 1ns/1ps
module sac_core_model (
  // Control block side.
  input wire [79:0] levels,
  input wire [2:0] analog_input_n,
  input wire [9:0] an_trial,
  input wire an_sleep,
  // Comparator.
  output wire an_cmp
);
  // High when the selected input lies above the trial word; inverted while asleep.
  wire [9:0] vin = levels[analog_input_n * 10 +: 10];
  assign an_cmp = an_sleep ^ (vin > an_trial);
endmodule

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the converter control block.
// Assumes: Divider 2, so a conversion clock is six system clocks.
// Notes: Reference settling is shortened; the model needs none.
`timescale 1ns/1ps
`include "sac_defines.vh"
module testbench;
  logic mclk, rst_n, sel, wr, be, ack, err, cmp, sleep, busy;
  logic [31:0] addr, wdata, rdata;
  logic [1:0] size;
  logic [2:0] chan;
  logic [9:0] trial, last;
  logic [33:0] rs;
  int error_cnt, checks_done;
  localparam logic [79:0] LV = {10'h3FF, 10'h37C, 10'h0F0, 10'h2AA,
    10'h001, 10'h155, 10'h200, 10'h000};
  localparam int P = 2;
  localparam logic [31:0] C = `SAC_CTRL_ADDR;
  localparam logic [31:0] R = `SAC_RES_ADDR;
  localparam logic [1:0] W = `SAC_SZ_WORD;
  sac_ctrl i_sac_ctrl (.mclk(mclk), .rst_n(rst_n), .bus_sel(sel), .bus_wr(wr),
    .bus_addr(addr), .bus_size(size), .bus_big_endian(be), .bus_wdata(wdata),
    .bus_rdata(rdata), .bus_ack(ack), .bus_err(err), .an_cmp(cmp),
    .analog_input_n(chan), .an_trial(trial), .an_sleep(sleep), .an_busy(busy));
  sac_core_model i_sac_core_model (.levels(LV), .analog_input_n(chan),
    .an_trial(trial), .an_sleep(sleep), .an_cmp(cmp));
  // Expected result: keep each trial bit while the input is above the trial.
  function automatic logic [9:0] sar(input logic [9:0] v);
    logic [9:0] r;
    r = 10'h000;
    for (int b = 9; b >= 0; b--) begin
      if (v > (r | (10'h001 << b))) begin
        r = r | (10'h001 << b);
      end
    end
    return r;
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access: strobe for a cycle, answer taken the cycle after.
  task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] s,
    input logic [31:0] d);
    @(negedge mclk);
    sel = 1'b1;
    wr = w;
    addr = a;
    size = s;
    wdata = d;
    @(negedge mclk);
    sel = 1'b0;
    rs = {err, ack, rdata};
  endtask
  task automatic rdc(input logic [31:0] a, input logic [1:0] s, input logic [31:0] x);
    acc(1'b0, a, s, 32'h0);
    chk(rs, {2'b01, x});
  endtask
  task automatic errc(input logic w, input logic [31:0] a, input logic [1:0] s);
    acc(w, a, s, 32'h0);
    chk(rs & 34'h300000000, 34'h200000000);
  endtask
  // Bounded poll of one control bit.
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      acc(1'b0, C, W, 32'h0);
      n++;
    end while (rs[b] !== v && n < 200);
    chk({33'h0, rs[b]}, {33'h0, v});
  endtask
  task automatic conv(input int c);
    acc(1'b1, C, W, c << 2);
    repeat (750) @(negedge mclk);
    acc(1'b1, C, W, (c << 2) | 1);
    poll(0, 1'b0);
    // The read that first shows start cleared falls inside the flag glitch.
    chk({33'h0, rs[6]}, 34'h1);
    repeat (8) @(negedge mclk);
    rdc(C, W, c << 2);
    poll(6, 1'b1);
    // The flag rises a conversion clock early, so the old result still stands.
    rdc(R, W, {22'h0, last});
    repeat (2 * (P + 1)) @(negedge mclk);
    last = sar(LV[c * 10 +: 10]);
    rdc(R, W, {22'h0, last});
    rdc(C, W, 32'h40 | (c << 2));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Watchdog with wide margin over the expected run.
  initial begin
    #(40000 * 20);
    error_cnt++;
    final_report();
  end
  // Main sequence.
  initial begin
    {rst_n, sel, wr, be, addr, size, wdata, last, error_cnt, checks_done} = '0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    rdc(C, W, 32'h20);
    rdc(C + 32'h4, `SAC_SZ_HALF, 32'h0);
    chk({33'h0, sleep}, 34'h1);
    rdc(C, `SAC_SZ_BYTE, 32'h20);
    be = 1'b1;
    rdc(C + `SAC_BE_B_OFS, `SAC_SZ_BYTE, 32'h20);
    rdc(C + `SAC_BE_HW_OFS, `SAC_SZ_HALF, 32'h20);
    be = 1'b0;
    errc(1'b0, R, `SAC_SZ_BYTE);
    errc(1'b1, R, W);
    errc(1'b0, R + 32'h4, W);
    $display("test access done");
    acc(1'b1, C + 32'h4, W, P);
    acc(1'b1, C, W, 32'h0);
    repeat (1000) @(negedge mclk);
    for (int c = 0; c < 8; c++) begin
      conv(c);
    end
    $display("test convert done");
    acc(1'b1, C, W, 32'h0);
    repeat (750) @(negedge mclk);
    acc(1'b1, C, W, 32'h1);
    repeat (40) @(negedge mclk);
    acc(1'b1, C, W, 32'h20);
    repeat (200) @(negedge mclk);
    chk({33'h0, busy}, 34'h0);
    rdc(R, W, {22'h0, last});
    $display("test sleep done");
    acc(1'b1, C, W, 32'h2);
    repeat (1000) @(negedge mclk);
    acc(1'b1, C, W, 32'h3);
    repeat (20) @(negedge mclk);
    chk({33'h0, busy}, 34'h0);
    acc(1'b0, R, W, 32'h0);
    repeat (20) @(negedge mclk);
    chk({33'h0, busy}, 34'h1);
    repeat (200) @(negedge mclk);
    rdc(R, W, {22'h0, sar(LV[9:0])});
    acc(1'b1, C, W, 32'h0);
    repeat (200) @(negedge mclk);
    acc(1'b0, R, W, 32'h0);
    repeat (20) @(negedge mclk);
    chk({33'h0, busy}, 34'h0);
    $display("test read start done");
    final_report();
  end
endmodule
